// >>> inc/srreo_pkg.sv
// srreo_pkg: opcodes, widths and operand carriers for the status-read,
// rotate and sign-extend datapath.
// assumes: issue logic decodes operations into these opcodes and slots.
package srreo_pkg;

  // ****************************************************************
  // widths and opcodes
  // ****************************************************************
  localparam int unsigned DATA_W = 32;
  localparam int unsigned DEST_W = 7;
  localparam int unsigned OPC_W = 8;
  localparam int unsigned SLOT_W = 3;
  localparam int unsigned IMM_W = 7;
  localparam int unsigned ROT_W = 5;
  localparam int unsigned HALF_W = 16;

  localparam logic [OPC_W-1:0] OPC_READ_STATUS = 8'h9E;  // 158
  localparam logic [OPC_W-1:0] OPC_READ_SRCPC = 8'h9D;   // 157
  localparam logic [OPC_W-1:0] OPC_ROTATE_REG = 8'h61;   // 97
  localparam logic [OPC_W-1:0] OPC_ROTATE_IMM = 8'h62;   // 98
  localparam logic [OPC_W-1:0] OPC_HALF_SEXT = 8'h33;    // 51

  // issue slot masks, bit k-1 means slot k
  localparam logic [4:0] SLOTS_READ = 5'h04;
  localparam logic [4:0] SLOTS_ROTATE = 5'h03;
  localparam logic [4:0] SLOTS_SEXT = 5'h1F;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [DATA_W-1:0] SRCPC_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RESULT_RESET = 32'h0000_0000;
  localparam logic [DEST_W-1:0] DEST_RESET = 7'h00;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic valid;
    logic [OPC_W-1:0] opcode;
    logic [SLOT_W-1:0] slot;
    logic [DATA_W-1:0] guard_operand;
    logic [DATA_W-1:0] first_source;
    logic [DATA_W-1:0] second_source;
    logic [IMM_W-1:0] modifier;
    logic [DEST_W-1:0] dest;
  } srreo_issue_t;

  typedef struct packed {
    logic valid;
    logic taken;
    logic noint;
    logic [DATA_W-1:0] target;
  } srreo_jump_t;

  typedef struct packed {
    logic we;
    logic [DEST_W-1:0] dest;
    logic [DATA_W-1:0] data;
  } srreo_wb_t;

endpackage : srreo_pkg

// >>> src/srreo_datapath.sv
// srreo_datapath: single-cycle execution of status read, source-counter
// read, rotate left (register/immediate) and halfword sign extend.
// assumes: one operation per cycle from same-clock issue logic; the
// status word is a live register input from the control unit.
// every op here has latency 1, so no stall or bypass path exists.
//
// Behaviour
// - read-status op 158 copies the whole status word to destination when guarded true
// - only guard bit 0 decides whether the destination is written
// - read-source-counter op 157 copies the source counter to destination
// - interruptible jump with nothing pending loads its target into source counter
// - register rotate op 97 takes amount from second_source bits 4 to 0
// - rotate left moves top n bits into bottom n positions
// - immediate rotate op 98 uses 7-bit modifier; issuer keeps it 0 to 31
// - sign-extend op 51 copies bit 15 into bits 31 to 16
`timescale 1ns/1ps

module srreo_datapath
  import srreo_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire srreo_issue_t issue_i,
  input wire srreo_jump_t jump_i,
  input wire logic [DATA_W-1:0] program_status_word_i,
  output srreo_wb_t wb_o,
  output logic [DATA_W-1:0] source_program_counter_o,
  output logic illegal_op_o
);

  // ****************************************************************
  // functions
  // ****************************************************************
  // modulo-32 rotate; amount 0 is the identity, never a shift-out
  function automatic logic [DATA_W-1:0] rotl(
    input logic [DATA_W-1:0] v,
    input logic [ROT_W-1:0] n
  );
    logic [2*DATA_W-1:0] dbl;
    dbl = {v, v} << n;
    return dbl[2*DATA_W-1:DATA_W];
  endfunction : rotl

  // slot k is bit k-1 of the mask; slot codes 0, 6 and 7 never match
  function automatic logic slot_ok(
    input logic [4:0] mask,
    input logic [SLOT_W-1:0] slot
  );
    logic ok;
    ok = 1'b0;
    if (slot >= 3'h1 && slot <= 3'h5) begin
      ok = mask[slot - 3'h1];
    end
    return ok;
  endfunction : slot_ok

  // opcode and slot must both agree before an op counts as decoded
  function automatic logic op_hit(
    input logic [OPC_W-1:0] code,
    input logic [SLOT_W-1:0] slot,
    input logic [OPC_W-1:0] want,
    input logic [4:0] mask
  );
    logic hit;
    hit = (code == want) && slot_ok(mask, slot);
    return hit;
  endfunction : op_hit

  function automatic logic [DATA_W-1:0] sext16(
    input logic [DATA_W-1:0] v
  );
    logic [DATA_W-1:0] ext;
    ext = {{(DATA_W-HALF_W){v[HALF_W-1]}}, v[HALF_W-1:0]};
    return ext;
  endfunction : sext16

  // ****************************************************************
  // state
  // ****************************************************************
  logic [DATA_W-1:0] srcpc_q;
  logic [DATA_W-1:0] srcpc_d;
  logic wb_we_q;
  logic wb_we_d;
  logic [DEST_W-1:0] wb_dest_q;
  logic [DEST_W-1:0] wb_dest_d;
  logic [DATA_W-1:0] wb_data_q;
  logic [DATA_W-1:0] wb_data_d;
  logic illegal_q;
  logic illegal_d;

  // ****************************************************************
  // operand fields
  // ****************************************************************
  wire logic op_valid = issue_i.valid;
  wire logic [OPC_W-1:0] op_code = issue_i.opcode;
  wire logic [SLOT_W-1:0] op_slot = issue_i.slot;
  wire logic [DATA_W-1:0] src_a = issue_i.first_source;
  wire logic [DATA_W-1:0] src_b = issue_i.second_source;
  wire logic [IMM_W-1:0] imm_n = issue_i.modifier;
  wire logic [DEST_W-1:0] op_dest = issue_i.dest;
  // only bit 0 of the guard counts; the upper bits are don't-care
  wire logic guard_true = issue_i.guard_operand[0];

  // ****************************************************************
  // decode
  // ****************************************************************
  wire logic is_status =
    op_hit(op_code, op_slot, OPC_READ_STATUS, SLOTS_READ);
  wire logic is_srcpc =
    op_hit(op_code, op_slot, OPC_READ_SRCPC, SLOTS_READ);
  wire logic is_rotr =
    op_hit(op_code, op_slot, OPC_ROTATE_REG, SLOTS_ROTATE);
  wire logic is_roti =
    op_hit(op_code, op_slot, OPC_ROTATE_IMM, SLOTS_ROTATE);
  wire logic is_sext =
    op_hit(op_code, op_slot, OPC_HALF_SEXT, SLOTS_SEXT);
  wire logic known =
    is_status | is_srcpc | is_rotr | is_roti | is_sext;
  // out-of-range immediate is the issuer's fault; flagged, low bits still used
  wire logic imm_bad = is_roti && (imm_n > 7'h1F);
  // an unknown or unguarded op writes nothing; an unknown op raises only the refused flag; an out-of-range immediate rotate is refused yet still written
  wire logic do_write = op_valid && known && guard_true;
  wire logic refused = op_valid && (!known || imm_bad);

  // ****************************************************************
  // results
  // ****************************************************************
  wire logic [ROT_W-1:0] amt_reg = src_b[ROT_W-1:0];
  wire logic [ROT_W-1:0] amt_imm = imm_n[ROT_W-1:0];
  wire logic [DATA_W-1:0] res_status = program_status_word_i;
  wire logic [DATA_W-1:0] res_srcpc = srcpc_q;
  wire logic [DATA_W-1:0] res_rotr = rotl(src_a, amt_reg);
  wire logic [DATA_W-1:0] res_roti = rotl(src_a, amt_imm);
  wire logic [DATA_W-1:0] res_sext = sext16(src_a);

  // decode is one-hot, so an and-or select needs no priority chain
  wire logic [DATA_W-1:0] sel_status = {DATA_W{is_status}} & res_status;
  wire logic [DATA_W-1:0] sel_srcpc = {DATA_W{is_srcpc}} & res_srcpc;
  wire logic [DATA_W-1:0] sel_rotr = {DATA_W{is_rotr}} & res_rotr;
  wire logic [DATA_W-1:0] sel_roti = {DATA_W{is_roti}} & res_roti;
  wire logic [DATA_W-1:0] sel_sext = {DATA_W{is_sext}} & res_sext;

  // no decoded op gives zero, which is never written anyway
  wire logic [DATA_W-1:0] result =
    sel_status | sel_srcpc | sel_rotr
    | sel_roti | sel_sext;

  // ****************************************************************
  // writeback
  // ****************************************************************
  // dest/data hold between writes so the port shows the last value written
  assign wb_we_d = do_write;
  assign wb_dest_d = do_write ? op_dest : wb_dest_q;
  assign wb_data_d = do_write ? result : wb_data_q;

  // ****************************************************************
  // source counter
  // ****************************************************************
  // a pending nmi, interrupt or exception clears noint: counter untouched
  wire logic jump_go = jump_i.valid && jump_i.taken && jump_i.noint;
  // a counter read in the jump's own cycle returns the old value
  assign srcpc_d = jump_go ? jump_i.target : srcpc_q;

  // ****************************************************************
  // refused ops
  // ****************************************************************
  // one pulse per refused op; the issuer decides what to do with it
  assign illegal_d = refused;

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wb_we_q <= 1'b0;
    end else begin
      wb_we_q <= wb_we_d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wb_dest_q <= DEST_RESET;
    end else begin
      wb_dest_q <= wb_dest_d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wb_data_q <= RESULT_RESET;
    end else begin
      wb_data_q <= wb_data_d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      srcpc_q <= SRCPC_RESET;
    end else begin
      srcpc_q <= srcpc_d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      illegal_q <= 1'b0;
    end else begin
      illegal_q <= illegal_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign wb_o = '{we: wb_we_q, dest: wb_dest_q, data: wb_data_q};
  assign source_program_counter_o = srcpc_q;
  assign illegal_op_o = illegal_q;

endmodule : srreo_datapath

// >>> bench/srreo_datapath_props.sv
// checker for the srreo_datapath ports
// assumes: bound to the datapath, one clock, sync reset
`timescale 1ns/1ps
module srreo_datapath_props
  import srreo_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire srreo_issue_t issue_i,
  input wire srreo_jump_t jump_i,
  input wire logic [DATA_W-1:0] program_status_word_i,
  input wire srreo_wb_t wb_o,
  input wire logic [DATA_W-1:0] source_program_counter_o,
  input wire logic illegal_op_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire [31:0] f = issue_i.first_source;
  wire g = issue_i.valid & issue_i.guard_operand[0];
  // slot kept to one legal value per op, so a refused op never trips a check
  wire [10:0] k = g ? {issue_i.slot, issue_i.opcode} : 11'h000;
  wire jt = jump_i.valid & jump_i.taken & jump_i.noint;
  wire [63:0] rr = {f, f} << issue_i.second_source[4:0];
  wire [63:0] ri = {f, f} << issue_i.modifier[4:0];
  wire [7:0] oc = issue_i.opcode;
  wire sr = issue_i.slot == 3'h3;
  wire s12 = issue_i.slot == 3'h1 || issue_i.slot == 3'h2;
  wire s15 = issue_i.slot >= 3'h1 && issue_i.slot <= 3'h5;
  wire ok_op = ((oc == OPC_READ_STATUS || oc == OPC_READ_SRCPC) && sr) || (oc == OPC_ROTATE_REG && s12)
    || (oc == OPC_ROTATE_IMM && s12 && issue_i.modifier < 7'h20) || (oc == OPC_HALF_SEXT && s15);
  a_illegal_flag: assert property (1'b1
    |=> illegal_op_o == $past(issue_i.valid && !ok_op)) else $error("refused op flag wrong");
  a_status_read: assert property (k == {3'h3, OPC_READ_STATUS}
    |=> wb_o.we && wb_o.data == $past(program_status_word_i)) else $error("status copy wrong");
  a_guard_off: assert property (issue_i.valid && !issue_i.guard_operand[0]
    |=> !wb_o.we && $stable(wb_o.data)) else $error("write under false guard");
  a_write_dest: assert property (wb_o.we |-> $past(g) && wb_o.dest == $past(issue_i.dest))
    else $error("stray write");
  a_counter_read: assert property (k == {3'h3, OPC_READ_SRCPC}
    |=> wb_o.we && wb_o.data == $past(source_program_counter_o)) else $error("counter copy wrong");
  a_jump_load: assert property (1'b1
    |=> source_program_counter_o == $past(jt ? jump_i.target : source_program_counter_o))
    else $error("counter update wrong");
  a_rotate_reg: assert property (k == {3'h1, OPC_ROTATE_REG}
    |=> wb_o.data == $past(rr[63:32])) else $error("register rotate wrong");
  a_rotate_imm: assert property (k == {3'h1, OPC_ROTATE_IMM} && issue_i.modifier < 7'h20
    |=> wb_o.data == $past(ri[63:32])) else $error("immediate rotate wrong");
  a_sign_ext: assert property (k == {3'h1, OPC_HALF_SEXT}
    |=> wb_o.data == {{16{$past(f[15])}}, $past(f[15:0])}) else $error("sign extend wrong");
endmodule : srreo_datapath_props

// >>> bench/srreo_regfile_model.sv
// register file fed by the writeback port
// assumes: same clock as the datapath; unwritten entries read A5A5A5A5
`timescale 1ns/1ps
module srreo_regfile_model
  import srreo_pkg::*;
(
  input wire logic core_clk_i,
  input wire srreo_wb_t wb_i,
  output logic [DATA_W-1:0] rf_o [128]
);
  initial begin
    rf_o = '{default: 32'hA5A5_A5A5};
    forever @(posedge core_clk_i) if (wb_i.we) rf_o[wb_i.dest] <= wb_i.data;
  end
endmodule : srreo_regfile_model

// >>> bench/status_read_rotate_extend_ops_tb_top.sv
// directed tests of srreo_datapath, results read from the register file model
// assumes: package, datapath, model and checker compiled first
`timescale 1ns/1ps
module status_read_rotate_extend_ops_tb_top
  import srreo_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1;
  srreo_issue_t iss = '0;
  srreo_jump_t jmp = '0;
  logic [31:0] source_program_counter, rf [128];
  srreo_wb_t wb;
  logic [31:0] psw = 32'h8011_0642;
  logic ill;
  int n_mismatch = 0, cmp_count = 0;
  always #2.5 clk = ~clk;
  srreo_datapath DUT (.core_clk_i(clk), .sys_rst_i(rst), .issue_i(iss), .jump_i(jmp),
    .program_status_word_i(psw), .wb_o(wb), .source_program_counter_o(source_program_counter), .illegal_op_o(ill));
  srreo_regfile_model RF (.core_clk_i(clk), .wb_i(wb), .rf_o(rf));
  task automatic chk(input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic op(input logic [7:0] o, input logic [2:0] sl, input logic [31:0] g, a, b, input logic [6:0] d);
    @(posedge clk) #1 iss = '{1'b1, o, sl, g, a, b, b[6:0], d};
  endtask : op
  task automatic fin();
    @(posedge clk) #1 iss.valid = 1'b0;
    jmp = '0;
    @(posedge clk) #1;
  endtask : fin
  task automatic t_read();
    op(OPC_READ_STATUS, 3'h3, 32'h1, '0, '0, 7'h01);
    op(OPC_READ_STATUS, 3'h3, 32'hFFFF_FFFE, '0, '0, 7'h02);
    psw = 32'h8000_0000;
    jmp = '{1'b1, 1'b1, 1'b1, 32'h00BE_EBEE};
    op(OPC_READ_SRCPC, 3'h3, 32'h1, '0, '0, 7'h03);
    jmp = '{1'b1, 1'b1, 1'b0, 32'h0000_ABBA};
    op(OPC_READ_STATUS, 3'h3, 32'h1, '0, '0, 7'h04);
    fin();
    chk(rf[1], 32'h8011_0642);
    chk(rf[4], 32'h8000_0000);
    chk(rf[2], 32'hA5A5_A5A5);
    chk(rf[3], 32'h00BE_EBEE);
    chk(source_program_counter, 32'h00BE_EBEE);
    $display("read test done");
  endtask : t_read
  task automatic t_alu();
    logic [7:0] o [7] = '{OPC_ROTATE_REG, OPC_ROTATE_REG, OPC_ROTATE_REG, OPC_ROTATE_IMM, OPC_ROTATE_IMM,
      OPC_HALF_SEXT, OPC_HALF_SEXT};
    logic [31:0] a [7] = '{32'h20, 32'hE, 32'h1234_5678, 32'h1234, 32'hE, 32'hFFFF_0040, 32'hFF0F_FF91};
    // issuer keeps the immediate amount within 0..31
    logic [31:0] b [7] = '{32'h3, 32'hFFFF_FFFE, 32'h20, 32'h0, 32'h1E, 32'h0, 32'h0};
    logic [31:0] e [7] = '{32'h100, 32'h8000_0003, 32'h1234_5678, 32'h1234, 32'h8000_0003, 32'h40,
      32'hFFFF_FF91};
    for (int i = 0; i < 7; i++) op(o[i], 3'h1, 32'h1, a[i], b[i], 7'(10 + i));
    fin();
    for (int i = 0; i < 7; i++) chk(rf[10 + i], e[i]);
    $display("alu test done");
  endtask : t_alu
  task automatic t_refuse();
    op(OPC_READ_STATUS, 3'h1, 32'h1, '0, '0, 7'h14);
    @(posedge clk) #1 iss.valid = 1'b0;
    chk(32'(ill), 32'h1);
    op(8'h00, 3'h1, 32'h1, '0, '0, 7'h15);
    @(posedge clk) #1 iss.valid = 1'b0;
    chk(32'(ill), 32'h1);
    fin();
    chk(32'(ill), 32'h0);
    chk(rf[20], 32'hA5A5_A5A5);
    chk(rf[21], 32'hA5A5_A5A5);
    $display("refuse test done");
  endtask : t_refuse
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  initial begin
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    t_read();
    t_alu();
    t_refuse();
    test_done();
  end
endmodule : status_read_rotate_extend_ops_tb_top
bind srreo_datapath srreo_datapath_props u_props (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
  .issue_i(issue_i), .jump_i(jump_i), .program_status_word_i(program_status_word_i), .wb_o(wb_o),
  .source_program_counter_o(source_program_counter_o), .illegal_op_o(illegal_op_o));
